// ==== ugps_pkg.sv ====
package ugps_pkg;

  // Register indices; byte address is four times the index
  localparam logic [31:0] REG_MODE_LO_IDX = 32'h0b00_0304;
  localparam logic [31:0] REG_MODE_HI_IDX = 32'h0b00_0306;
  localparam logic [31:0] REG_DATA_IDX = 32'h0b00_0308;

  // Field layout: two bits per pin, pin 16 + n at bits 2n+1:2n
  localparam int PIN_COUNT = 16;
  localparam int FIELD_W = 2;
  localparam int REG_W = 16;
  localparam int LCD_PIN_IDX = 4;

  // Reset values on the real-time-clock domain reset
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Field codes
  localparam logic [1:0] CODE_GPI = 2'h0;
  localparam logic [1:0] CODE_ALT_IN = 2'h1;
  localparam logic [1:0] CODE_GPO = 2'h2;
  localparam logic [1:0] CODE_ALT_OUT = 2'h3;

  // Pins whose alternate function is an output or an input
  localparam logic [15:0] ALT_OUT_MASK = 16'h4df3;
  localparam logic [15:0] ALT_IN_MASK = 16'hb20c;

  typedef enum logic [2:0] {
    KIND_GPI, KIND_GPO, KIND_ALT_OUT, KIND_ALT_IN, KIND_RSVD
  } ugps_kind_e;

  typedef enum logic {BUS_IDLE, BUS_ACK} ugps_bus_e;

  // Alternate-function outputs arriving from the peripherals
  typedef struct packed {
    logic boot_rom_select_0_n;
    logic boot_rom_select_1_n;
    logic boot_rom_select_2_n;
    logic system_reset_n;
    logic lcd_alternating_signal;
    logic upper_byte_enable_n;
    logic io_write_strobe_n;
    logic io_read_strobe_n;
    logic primary_uart_terminal_ready_out;
    logic primary_uart_request_to_send_out;
    logic primary_uart_transmit_out;
  } ugps_alt_out_s;

  // Alternate-function inputs handed to the peripherals
  typedef struct packed {
    logic io_wide_cycle_request_n;
    logic io_cycle_ready;
    logic primary_uart_set_ready_in;
    logic primary_uart_carrier_detect_in;
    logic primary_uart_clear_to_send_in;
    logic primary_uart_receive_in;
  } ugps_alt_in_s;

endpackage

// ==== ugps_top.sv ====
`timescale 1ns/1ps

// What this block does
// R1: Pin 23 code 11 drives boot select 1
// R2: Pin 22 code 11 drives ROM select 0
// R3: Pin 21 code 11 drives reset output
// R4: Pin 20: 10 LCD signal, 11 byte enable
// R5: Pin 19 code 01 feeds wide-cycle request
// R6: Pin 18 code 01 feeds I/O ready
// R7: Pin 17 code 11 drives write strobe
// R8: Pin 16 code 11 drives read strobe
// R9: Pin 31 code 01 feeds set-ready input
// R10: Pin 30 code 11 drives terminal ready
// R11: Pin 29 code 01 feeds carrier detect
// R12: Pin 28 code 01 feeds clear to send
// R13: Pin 27 code 11 drives request to send
// R14: Pin 26 code 11 drives transmit data
// R15: Pin 25 code 01 feeds receive data
// R16: Pin 24 code 11 drives ROM select 2
// R17: RTC reset clears modes; others keep them
// R18: Software avoids LCD signal on first revision
// R19: Data bit reads input, drives output
// R20: Reserved code: undriven input, inactive alternate
// R21: Mode write acts next cycle; reads unchanged
module ugps_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic rtc_domain_reset,
  // Avalon-MM slave, word addressed
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins 16 to 31
  input wire logic [15:0] pin_level_in,
  output logic [15:0] pin_drive_out,
  output logic [15:0] pin_drive_oe,
  // Peripheral side
  input wire ugps_pkg::ugps_alt_out_s alt_out_i,
  output ugps_pkg::ugps_alt_in_s alt_in_o
);

  function automatic ugps_pkg::ugps_kind_e pin_kind(
    input int idx,
    input logic [1:0] code
  );
    ugps_pkg::ugps_kind_e k;
    k = ugps_pkg::KIND_RSVD;
    case (code)
      ugps_pkg::CODE_GPI: k = ugps_pkg::KIND_GPI;
      ugps_pkg::CODE_ALT_IN: begin
        if (ugps_pkg::ALT_IN_MASK[idx]) k = ugps_pkg::KIND_ALT_IN;
      end
      ugps_pkg::CODE_GPO: begin
        if (idx == ugps_pkg::LCD_PIN_IDX) k = ugps_pkg::KIND_ALT_OUT;
        else k = ugps_pkg::KIND_GPO;
      end
      default: begin
        if (ugps_pkg::ALT_OUT_MASK[idx]) k = ugps_pkg::KIND_ALT_OUT;
      end
    endcase
    return k;
  endfunction

  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] m;
    m = old;
    if (be[0]) m[7:0] = wd[7:0];
    if (be[1]) m[15:8] = wd[15:8];
    return m;
  endfunction

  logic [15:0] mode_lo_q;
  logic [15:0] mode_hi_q;
  logic [15:0] data_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [31:0] readdata_q;
  ugps_pkg::ugps_bus_e bus_q;
  logic [31:0] modes;
  logic [15:0] alt_vec;
  logic [15:0] read_vec;
  ugps_pkg::ugps_kind_e kind_w [ugps_pkg::PIN_COUNT];
  logic req;
  logic wr_fire;
  logic hit_lo;
  logic hit_hi;
  logic hit_data;

  assign modes = {mode_hi_q, mode_lo_q};
  assign req = avs_read || avs_write;
  assign hit_lo = avs_address == ugps_pkg::REG_MODE_LO_IDX;
  assign hit_hi = avs_address == ugps_pkg::REG_MODE_HI_IDX;
  assign hit_data = avs_address == ugps_pkg::REG_DATA_IDX;

  // One wait cycle: request seen, then answered on the next edge.
  // The answer is held back while ce is low, so no write is lost.
  assign avs_waitrequest = req && !(ce && bus_q == ugps_pkg::BUS_ACK);
  assign wr_fire = ce && avs_write && (bus_q == ugps_pkg::BUS_ACK);
  assign avs_readdata = readdata_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_q <= ugps_pkg::BUS_IDLE;
    end else if (ce) begin
      case (bus_q)
        ugps_pkg::BUS_IDLE: begin
          if (req) bus_q <= ugps_pkg::BUS_ACK;
        end
        default: bus_q <= ugps_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read data is latched while waitrequest is high, stands at the answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      readdata_q <= 32'h0000_0000;
    end else if (ce && avs_read && bus_q == ugps_pkg::BUS_IDLE) begin
      if (hit_lo) begin
        readdata_q <= {16'h0000, mode_lo_q}; // see R21
      end else if (hit_hi) begin
        readdata_q <= {16'h0000, mode_hi_q}; // see R21
      end else if (hit_data) begin
        readdata_q <= {16'h0000, read_vec};
      end else begin
        readdata_q <= 32'h0000_0000;
      end
    end
  end

  // Modes answer only to the RTC reset, so a warm reset keeps the pinout
  always_ff @(posedge clk) begin
    if (ce) begin
      if (rtc_domain_reset) begin
        mode_lo_q <= ugps_pkg::MODE_RST; // see R17
        mode_hi_q <= ugps_pkg::MODE_RST; // see R17
      end else if (wr_fire && hit_lo) begin
        mode_lo_q <= merge_lanes(mode_lo_q, avs_writedata,
                                 avs_byteenable); // see R21
      end else if (wr_fire && hit_hi) begin
        mode_hi_q <= merge_lanes(mode_hi_q, avs_writedata,
                                 avs_byteenable); // see R21
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      if (rtc_domain_reset) begin
        data_q <= ugps_pkg::DATA_RST;
      end else if (wr_fire && hit_data) begin
        data_q <= merge_lanes(data_q, avs_writedata, avs_byteenable);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else if (ce) begin
      sync1_q <= pin_level_in;
      sync2_q <= sync1_q;
    end
  end

  // Alternate output per pin; unused positions idle high
  always_comb begin
    alt_vec = 16'hffff;
    alt_vec[0] = alt_out_i.io_read_strobe_n; // see R8
    alt_vec[1] = alt_out_i.io_write_strobe_n; // see R7
    if (mode_lo_q[9:8] == ugps_pkg::CODE_GPO) begin
      alt_vec[4] = alt_out_i.lcd_alternating_signal; // see R4
    end else begin
      alt_vec[4] = alt_out_i.upper_byte_enable_n; // see R4
    end
    alt_vec[5] = alt_out_i.system_reset_n; // see R3
    alt_vec[6] = alt_out_i.boot_rom_select_0_n; // see R2
    alt_vec[7] = alt_out_i.boot_rom_select_1_n; // see R1
    alt_vec[8] = alt_out_i.boot_rom_select_2_n; // see R16
    alt_vec[10] = alt_out_i.primary_uart_transmit_out; // see R14
    alt_vec[11] = alt_out_i.primary_uart_request_to_send_out; // see R13
    alt_vec[14] = alt_out_i.primary_uart_terminal_ready_out; // see R10
  end

  // Pin mux is combinational from the mode flops so strobes keep timing
  genvar gi;
  generate
    for (gi = 0; gi < ugps_pkg::PIN_COUNT; gi++) begin : g_pin
      assign kind_w[gi] = pin_kind(gi,
        modes[gi*ugps_pkg::FIELD_W +: ugps_pkg::FIELD_W]);
      assign pin_drive_oe[gi] = (kind_w[gi] == ugps_pkg::KIND_GPO) ||
        (kind_w[gi] == ugps_pkg::KIND_ALT_OUT); // see R20
      assign pin_drive_out[gi] = (kind_w[gi] == ugps_pkg::KIND_GPO) ?
        data_q[gi] : alt_vec[gi]; // see R19
      assign read_vec[gi] = (kind_w[gi] == ugps_pkg::KIND_GPO) ? data_q[gi] :
        ((kind_w[gi] == ugps_pkg::KIND_GPI ||
          kind_w[gi] == ugps_pkg::KIND_RSVD) ? sync2_q[gi] : 1'b0); // see R19
    end
  endgenerate

  // Inputs not routed to a pin sit at their idle level
  always_comb begin
    alt_in_o.io_wide_cycle_request_n =
      (kind_w[3] == ugps_pkg::KIND_ALT_IN) ? sync2_q[3] : 1'b1; // see R5
    alt_in_o.io_cycle_ready =
      (kind_w[2] == ugps_pkg::KIND_ALT_IN) ? sync2_q[2] : 1'b1; // see R6
    alt_in_o.primary_uart_set_ready_in =
      (kind_w[15] == ugps_pkg::KIND_ALT_IN) ? sync2_q[15] : 1'b1; // see R9
    alt_in_o.primary_uart_carrier_detect_in =
      (kind_w[13] == ugps_pkg::KIND_ALT_IN) ? sync2_q[13] : 1'b1; // see R11
    alt_in_o.primary_uart_clear_to_send_in =
      (kind_w[12] == ugps_pkg::KIND_ALT_IN) ? sync2_q[12] : 1'b1; // see R12
    alt_in_o.primary_uart_receive_in =
      (kind_w[9] == ugps_pkg::KIND_ALT_IN) ? sync2_q[9] : 1'b1; // see R15
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  pin23_rom_a: // see R1
    assert property (mode_lo_q[15:14] == 2'h3 |->
      pin_drive_oe[7] && pin_drive_out[7] == alt_out_i.boot_rom_select_1_n)
    else $error("pin 23 not driving boot select 1");

  pin22_rom_a: // see R2
    assert property (mode_lo_q[13:12] == 2'h3 |->
      pin_drive_oe[6] && pin_drive_out[6] == alt_out_i.boot_rom_select_0_n)
    else $error("pin 22 not driving rom select 0");

  pin21_reset_a: // see R3
    assert property (mode_lo_q[11:10] == 2'h3 |->
      pin_drive_oe[5] && pin_drive_out[5] == alt_out_i.system_reset_n)
    else $error("pin 21 not driving reset");

  pin20_alt_a: // see R4
    assert property (mode_lo_q[9] |-> pin_drive_oe[4] &&
      pin_drive_out[4] == (mode_lo_q[8] ? alt_out_i.upper_byte_enable_n :
      alt_out_i.lcd_alternating_signal))
    else $error("pin 20 alternate output wrong");

  pin19_wide_a: // see R5
    assert property (mode_lo_q[7:6] == 2'h1 |-> !pin_drive_oe[3] &&
      alt_in_o.io_wide_cycle_request_n == $past(pin_level_in[3], 2))
    else $error("pin 19 wide request not routed");

  pin18_ready_a: // see R6
    assert property (mode_lo_q[5:4] == 2'h1 |-> !pin_drive_oe[2] &&
      alt_in_o.io_cycle_ready == sync2_q[2])
    else $error("pin 18 ready not routed");

  pin17_wr_a: // see R7
    assert property (mode_lo_q[3:2] == 2'h3 |->
      pin_drive_oe[1] && pin_drive_out[1] == alt_out_i.io_write_strobe_n)
    else $error("pin 17 not driving write strobe");

  pin16_rd_a: // see R8
    assert property (mode_lo_q[1:0] == 2'h3 |->
      pin_drive_oe[0] && pin_drive_out[0] == alt_out_i.io_read_strobe_n)
    else $error("pin 16 not driving read strobe");

  pin31_dsr_a: // see R9
    assert property (mode_hi_q[15:14] == 2'h1 |-> !pin_drive_oe[15] &&
      alt_in_o.primary_uart_set_ready_in == sync2_q[15])
    else $error("pin 31 set ready not routed");

  pin30_dtr_a: // see R10
    assert property (mode_hi_q[13:12] == 2'h3 |-> pin_drive_oe[14] &&
      pin_drive_out[14] == alt_out_i.primary_uart_terminal_ready_out)
    else $error("pin 30 not driving terminal ready");

  pin29_dcd_a: // see R11
    assert property (mode_hi_q[11:10] == 2'h1 |-> !pin_drive_oe[13] &&
      alt_in_o.primary_uart_carrier_detect_in == sync2_q[13])
    else $error("pin 29 carrier detect not routed");

  pin28_cts_a: // see R12
    assert property (mode_hi_q[9:8] == 2'h1 |-> !pin_drive_oe[12] &&
      alt_in_o.primary_uart_clear_to_send_in == sync2_q[12])
    else $error("pin 28 clear to send not routed");

  pin27_rts_a: // see R13
    assert property (mode_hi_q[7:6] == 2'h3 |-> pin_drive_oe[11] &&
      pin_drive_out[11] == alt_out_i.primary_uart_request_to_send_out)
    else $error("pin 27 not driving request to send");

  pin26_txd_a: // see R14
    assert property (mode_hi_q[5:4] == 2'h3 |-> pin_drive_oe[10] &&
      pin_drive_out[10] == alt_out_i.primary_uart_transmit_out)
    else $error("pin 26 not driving transmit");

  pin25_rxd_a: // see R15
    assert property (mode_hi_q[3:2] == 2'h1 |-> !pin_drive_oe[9] &&
      alt_in_o.primary_uart_receive_in == sync2_q[9])
    else $error("pin 25 receive not routed");

  pin24_rom_a: // see R16
    assert property (mode_hi_q[1:0] == 2'h3 |->
      pin_drive_oe[8] && pin_drive_out[8] == alt_out_i.boot_rom_select_2_n)
    else $error("pin 24 not driving rom select 2");

  rtc_clear_a: // see R17
    assert property (ce && rtc_domain_reset |=>
      modes == 32'h0000_0000 && pin_drive_oe == 16'h0000)
    else $error("rtc reset did not clear modes");

  warm_hold_a: // see R17
    assert property (@(posedge clk) disable iff (1'b0)
      !resetn && !rtc_domain_reset && !wr_fire |=> $stable(modes))
    else $error("warm reset disturbed modes");

  gpo_drive_a: // see R19
    assert property (mode_hi_q[15:14] == 2'h2 |->
      pin_drive_oe[15] && pin_drive_out[15] == data_q[15])
    else $error("output data bit not on pin");

  gpi_read_a: // see R19
    assert property (ce && avs_read && hit_data && !avs_waitrequest &&
      mode_lo_q[1:0] == 2'h0 |-> avs_readdata[0] == $past(sync2_q[0]))
    else $error("input pin level not read back");

  rsvd_idle_a: // see R20
    assert property ((mode_lo_q[1:0] != 2'h1 || !pin_drive_oe[0]) &&
      (mode_lo_q[7:6] != 2'h3 ||
       (!pin_drive_oe[3] && alt_in_o.io_wide_cycle_request_n)))
    else $error("reserved code drove pin or input");

  write_next_a: // see R21
    assert property (wr_fire && hit_hi && avs_byteenable[1:0] == 2'h3 &&
      !rtc_domain_reset |=> mode_hi_q == $past(avs_writedata[15:0]))
    else $error("mode write not applied next cycle");

  bus_answer_a:
    assert property (ce && req && bus_q == ugps_pkg::BUS_IDLE |=>
      !avs_waitrequest || !ce)
    else $error("bus answer later than one cycle");

  write_mode_c: cover property (wr_fire && hit_lo);
  read_data_c: cover property (ce && avs_read && hit_data &&
    !avs_waitrequest);
  lcd_sel_c: cover property (mode_lo_q[9:8] == 2'h2);
  uart_rx_c: cover property (mode_hi_q[3:2] == 2'h1);

endmodule

// ==== ugps_tb.sv ====
`timescale 1ns/1ps

module testbench;
  logic clk;
  logic resetn;
  logic ce;
  logic rtc_domain_reset;
  logic [31:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] pin_level_in;
  logic [15:0] pin_drive_out;
  logic [15:0] pin_drive_oe;
  ugps_pkg::ugps_alt_out_s alt_out_i;
  ugps_pkg::ugps_alt_in_s alt_in_o;
  int miscompares;
  int check_count;
  logic [31:0] rdata;
  logic [15:0] mode_v;
  logic [15:0] lvl;
  logic [15:0] eoe;
  logic [1:0] code;

  ugps_top dut (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .rtc_domain_reset(rtc_domain_reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pin_level_in(pin_level_in),
    .pin_drive_out(pin_drive_out),
    .pin_drive_oe(pin_drive_oe),
    .alt_out_i(alt_out_i),
    .alt_in_o(alt_in_o)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge, and the
  // request is released only at the edge that completes it
  task automatic bus_xfer(input logic wr, input logic [31:0] addr,
                          input logic [31:0] wd, input logic [3:0] be,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        miscompares++;
        tally_and_finish();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [15:0] d);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, {16'h0000, d}, 4'hf, dummy);
  endtask

  task automatic rd_check(input logic [31:0] addr, input logic [15:0] exp);
    logic [31:0] r;
    bus_xfer(1'b0, addr, 32'h0000_0000, 4'hf, r);
    check(r, {16'h0000, exp});
  endtask

  // Alternate outputs as they should land on pins under code 11
  function automatic logic [15:0] alt_vec(input ugps_pkg::ugps_alt_out_s a);
    logic [15:0] v;
    v = 16'h0000;
    v[0] = a.io_read_strobe_n;
    v[1] = a.io_write_strobe_n;
    v[4] = a.upper_byte_enable_n;
    v[5] = a.system_reset_n;
    v[6] = a.boot_rom_select_0_n;
    v[7] = a.boot_rom_select_1_n;
    v[8] = a.boot_rom_select_2_n;
    v[10] = a.primary_uart_transmit_out;
    v[11] = a.primary_uart_request_to_send_out;
    v[14] = a.primary_uart_terminal_ready_out;
    return v;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    miscompares = 0;
    check_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    rtc_domain_reset = 1'b1;
    avs_address = 32'h0000_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    pin_level_in = 16'h0000;
    alt_out_i = 11'h000;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rtc_domain_reset <= 1'b0;
    @(posedge clk);
    #1 check(32'(pin_drive_oe), 32'h0000_0000);
    rd_check(ugps_pkg::REG_MODE_LO_IDX, 16'h0000);
    rd_check(ugps_pkg::REG_MODE_HI_IDX, 16'h0000);
    wr(ugps_pkg::REG_DATA_IDX, 16'ha5c3);
    for (int c = 0; c < 4; c++) begin
      code = 2'(c);
      mode_v = {8{code}};
      wr(ugps_pkg::REG_MODE_LO_IDX, mode_v);
      wr(ugps_pkg::REG_MODE_HI_IDX, mode_v);
      eoe = (code == 2'h2) ? 16'hffff : (code == 2'h3) ? 16'h4df3 : 16'h0000;
      // Change takes hold in the cycle right after the completing edge
      #1 check(32'(pin_drive_oe), 32'(eoe));
      rd_check(ugps_pkg::REG_MODE_LO_IDX, mode_v);
      rd_check(ugps_pkg::REG_MODE_HI_IDX, mode_v);
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        lvl = (k % 2) ? ~(16'h0001 << k) : (16'h0001 << k);
        pin_level_in <= lvl;
        alt_out_i <= (k % 2) ? ~(11'h001 << (k % 11)) : (11'h001 << (k % 11));
        repeat (3) @(posedge clk);
        #1;
        check(32'(pin_drive_oe), 32'(eoe));
        if (code == 2'h3) begin
          check(32'(pin_drive_out & eoe),
                32'(alt_vec(alt_out_i) & eoe));
        end
        if (code == 2'h2) begin
          // LCD signal is used as on a later revision
          check(32'(pin_drive_out),
                32'(16'ha5c3 & 16'hffef) |
                32'({alt_out_i.lcd_alternating_signal, 4'h0}));
        end
        if (code == 2'h1) begin
          check(32'(alt_in_o),
                32'({lvl[3], lvl[2], lvl[15], lvl[13], lvl[12], lvl[9]}));
        end else begin
          check(32'(alt_in_o), 32'h0000_003f);
        end
      end
      if (code == 2'h0) begin
        rd_check(ugps_pkg::REG_DATA_IDX, lvl);
      end
      if (code == 2'h2) begin
        bus_xfer(1'b0, ugps_pkg::REG_DATA_IDX, 32'h0000_0000, 4'hf, rdata);
        check(rdata & 32'h0000_ffef,
              32'h0000_a5c3 & 32'h0000_ffef);
      end
    end
    // Lane 0 only: upper byte of the mode register must keep zero
    wr(ugps_pkg::REG_MODE_LO_IDX, 16'h0000);
    bus_xfer(1'b1, ugps_pkg::REG_MODE_LO_IDX, 32'h0000_ffff, 4'h1, rdata);
    rd_check(ugps_pkg::REG_MODE_LO_IDX, 16'h00ff);
    // Unmapped place: write dropped, read gives zero
    wr(32'h0b00_0310, 16'hffff);
    rd_check(32'h0b00_0310, 16'h0000);
    rd_check(ugps_pkg::REG_MODE_HI_IDX, 16'hffff);
    // Clock enable low: an RTC reset must not reach the frozen modes
    @(posedge clk);
    ce <= 1'b0;
    rtc_domain_reset <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rtc_domain_reset <= 1'b0;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd_check(ugps_pkg::REG_MODE_LO_IDX, 16'h00ff);
    rd_check(ugps_pkg::REG_MODE_HI_IDX, 16'hffff);
    @(posedge clk);
    rtc_domain_reset <= 1'b1;
    @(posedge clk);
    rtc_domain_reset <= 1'b0;
    @(posedge clk);
    #1 check(32'(pin_drive_oe), 32'h0000_0000);
    rd_check(ugps_pkg::REG_MODE_LO_IDX, 16'h0000);
    rd_check(ugps_pkg::REG_MODE_HI_IDX, 16'h0000);
    tally_and_finish();
  end
endmodule
